// >>> rtl/rtcesc_pkg.sv
// constants and carrier types for the clock event status and control block
package rtcesc_pkg;

    // ============================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_EVT_ENABLE = 8'h0b;
    localparam logic [7:0] IDX_EVT_STATUS = 8'h0c;
    localparam logic [7:0] IDX_DAY_MATCH  = 8'h0d;
    localparam logic [7:0] IDX_CLK_CTRL   = 8'h10;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h21;

    // ============================================================
    // field positions
    localparam int SUMMARY_BIT  = 7;
    localparam int PERIODIC_BIT = 6;
    localparam int ALARM_BIT    = 5;
    localparam int UPDATE_BIT   = 4;
    localparam int ALM_EN_BIT   = 3;
    localparam int WAKE_BIT     = 2;
    localparam int SOFTRST_BIT  = 1;
    localparam int BLOCK_EN_BIT = 0;
    localparam int DAY_W        = 6;
    localparam int EVT_N        = 3;

    // ============================================================
    // reset values
    localparam logic [7:0]       CTRL_RST    = 8'h00;
    localparam logic [DAY_W-1:0] DAY_RST     = 6'h00;
    localparam logic [EVT_N-1:0] EVT_RST     = 3'h0;
    localparam logic [31:0]      RDATA_RST   = 32'h0000_0000;

    // ============================================================
    // timing
    localparam longint CLK_PERIOD_NS = 100;
    localparam longint STABLE_MS     = 999;
    // more than the stable time: round up, then one cycle beyond
    localparam longint STABLE_CYC    =
        (STABLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int     HOLD_W        = 24;

    // ============================================================
    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ    = 2'b11;

    // ============================================================
    // carrier types
    typedef struct packed {
        logic periodic;
        logic alarm;
        logic update;
    } rtcesc_evt_s;

    typedef struct packed {
        logic alarmEn;
        logic wakeOutGate;
        logic softRst;
        logic blockEn;
    } rtcesc_ctrl_s;

    typedef enum logic [1:0] {
        DP_IDLE,
        DP_READ,
        DP_WRITE
    } rtcesc_dphase_e;

endpackage

// >>> rtl/rtcesc_flag.sv
// sticky flag vector: set wins over a clear in the same cycle
`timescale 1ns/1ps
module rtcesc_flag
    import rtcesc_pkg::*;
#(
    parameter int W = 3
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] set,
    input  wire logic         clr,
    output logic      [W-1:0] flags
);

    logic [W-1:0] flag_ff;
    logic [W-1:0] nxt_flag;

    assign nxt_flag = set | (clr ? '0 : flag_ff);

    always_ff @(posedge clock) begin
        if (rst) begin
            flag_ff <= '0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flags = flag_ff;

endmodule

// >>> rtl/rtcesc_core.sv
// clock event status, date match alarm and clock control with ahb-lite slave
// What this block does
// - summary flag set when any event flag and its enable both set
// - reading event status clears summary and all event flags, except a flag set on the read edge
// - periodic event sets bit 6, held until read, enable ignored
// - alarm match sets bit 5, held until read, enable ignored
// - update completion sets bit 4, held until read, enable ignored
// - after update done, time registers stay unchanged over 999 ms
// - nonzero day match field blocks alarm unless equal to calendar
// - day match field zero is don't-care for the alarm
// - alarm features work only while control bit 3 is one
// - control bit 2 gates alarm onto wake output and aggregator
// - writing control bit 1 resets block except control register, bus phase capture and read data
// - soft reset bit clears itself when the reset finishes
// - block runs only while control bit 0 is one
// - enable bits 6,5,4 decide which events become interrupts
`timescale 1ns/1ps
module rtcesc_core
    import rtcesc_pkg::*;
#(
    parameter int HOLD_CYCLES = int'(STABLE_CYC)
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // events from the time keeping logic, same clock
    input  wire logic        periodicTick,
    input  wire logic        timeMatch,
    input  wire logic        updateDone,
    input  wire logic [7:0]  calMonth,
    // outputs
    output logic             updateHold,
    output logic             alarmWake,
    output logic             irq
);

    // ============================================================
    // reset domains
    // control, bus phase capture and read data survive the soft reset; everything else does not
    logic         softRst_ff;
    logic         domRst;

    assign domRst = !rstn || softRst_ff;

    // ============================================================
    // ahb address phase capture
    logic           addrTaken;
    rtcesc_dphase_e dphase_ff;
    rtcesc_dphase_e nxt_dphase;
    logic [7:0]     wIdx_ff;
    logic [7:0]     aIdx;
    logic           idxAligned;

    assign addrTaken  = hsel && hready && (htrans == HTRANS_NONSEQ
                                           || htrans == HTRANS_SEQ);
    assign aIdx       = haddr[9:2];
    assign idxAligned = (haddr[1:0] == 2'b00) && (haddr[31:10] == '0);

    always_comb begin
        nxt_dphase = DP_IDLE;
        if (addrTaken) begin
            nxt_dphase = hwrite ? DP_WRITE : DP_READ;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            dphase_ff <= DP_IDLE;
            wIdx_ff   <= 8'h00;
        end else begin
            dphase_ff <= nxt_dphase;
            wIdx_ff   <= idxAligned ? aIdx : 8'hff;
        end
    end

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic wrStrobe;
    logic rdStatus;

    always_comb begin
        wrStrobe = 1'b0;
        case (dphase_ff)
            DP_WRITE: wrStrobe = 1'b1;
            DP_READ:  wrStrobe = 1'b0;
            DP_IDLE:  wrStrobe = 1'b0;
            default:  wrStrobe = 1'b0;
        endcase
    end

    // read side effects fire as the address phase is taken, the same
    // edge that latches the read data
    assign rdStatus = addrTaken && !hwrite && idxAligned
                      && aIdx == IDX_EVT_STATUS;

    // ============================================================
    // clock control register
    rtcesc_ctrl_s ctrl_ff;
    logic         ctrlWr;

    assign ctrlWr = wrStrobe && wIdx_ff == IDX_CLK_CTRL;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctrl_ff <= rtcesc_ctrl_s'(CTRL_RST[3:0]);
        end else if (ctrlWr) begin
            ctrl_ff.alarmEn     <= hwdata[ALM_EN_BIT];
            ctrl_ff.wakeOutGate <= hwdata[WAKE_BIT];
            ctrl_ff.softRst     <= 1'b0;
            ctrl_ff.blockEn     <= hwdata[BLOCK_EN_BIT];
        end
    end

    // soft reset: one cycle of domain reset, then self clearing
    always_ff @(posedge clock) begin
        if (!rstn) begin
            softRst_ff <= 1'b0;
        end else if (ctrlWr && hwdata[SOFTRST_BIT]) begin
            softRst_ff <= 1'b1;
        end else begin
            softRst_ff <= 1'b0;
        end
    end

    // ============================================================
    // event enable and day match registers
    logic [EVT_N-1:0] evtEn_ff;
    logic [DAY_W-1:0] dayMatch_ff;

    always_ff @(posedge clock) begin
        if (domRst) begin
            evtEn_ff <= EVT_RST;
        end else if (wrStrobe && wIdx_ff == IDX_EVT_ENABLE) begin
            evtEn_ff <= hwdata[PERIODIC_BIT:UPDATE_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (domRst) begin
            dayMatch_ff <= DAY_RST;
        end else if (wrStrobe && wIdx_ff == IDX_DAY_MATCH) begin
            dayMatch_ff <= hwdata[DAY_W-1:0];
        end
    end

    // ============================================================
    // event qualification
    logic        dayOk;
    logic        alarmEvt;
    rtcesc_evt_s evtSet;
    rtcesc_evt_s evtFlags;

    assign dayOk = (dayMatch_ff == DAY_RST)
                   || ({2'b00, dayMatch_ff} == calMonth);

    // no alarm at all while the alarm features or the block are off
    assign alarmEvt = timeMatch && dayOk && ctrl_ff.alarmEn
                      && ctrl_ff.blockEn;

    assign evtSet.periodic = periodicTick && ctrl_ff.blockEn;
    assign evtSet.alarm    = alarmEvt;
    assign evtSet.update   = updateDone && ctrl_ff.blockEn;

    // ============================================================
    // event status flags
    logic [EVT_N-1:0] evtFlagVec;

    rtcesc_flag #(
        .W (EVT_N)
    ) u_evtFlags (
        .clock (clock),
        .rst   (domRst),
        .set   (evtSet),
        .clr   (rdStatus),
        .flags (evtFlagVec)
    );

    assign evtFlags = rtcesc_evt_s'(evtFlagVec);

    logic summary;

    assign summary = |(evtFlagVec & evtEn_ff);

    // ============================================================
    // interrupt status and mask
    logic [EVT_N-1:0] irqSet;
    logic [EVT_N-1:0] irqFlags;
    logic [EVT_N-1:0] irqMask_ff;
    logic             rdIrq;

    // aggregator alarm only passes with the wake gate open
    assign irqSet = {evtSet.periodic,
                     evtSet.alarm && ctrl_ff.wakeOutGate,
                     evtSet.update} & evtEn_ff;

    assign rdIrq = addrTaken && !hwrite && idxAligned
                   && aIdx == IDX_IRQ_STATUS;

    rtcesc_flag #(
        .W (EVT_N)
    ) u_irqFlags (
        .clock (clock),
        .rst   (domRst),
        .set   (irqSet),
        .clr   (rdIrq),
        .flags (irqFlags)
    );

    always_ff @(posedge clock) begin
        if (domRst) begin
            irqMask_ff <= EVT_RST;
        end else if (wrStrobe && wIdx_ff == IDX_IRQ_MASK) begin
            irqMask_ff <= hwdata[PERIODIC_BIT:UPDATE_BIT];
        end
    end

    logic irq_ff;

    always_ff @(posedge clock) begin
        if (domRst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irqFlags & irqMask_ff);
        end
    end

    assign irq = irq_ff;

    // ============================================================
    // alarm wake output
    logic alarmWake_ff;

    always_ff @(posedge clock) begin
        if (domRst) begin
            alarmWake_ff <= 1'b0;
        end else begin
            alarmWake_ff <= alarmEvt && ctrl_ff.wakeOutGate;
        end
    end

    assign alarmWake = alarmWake_ff;

    // ============================================================
    // time stable window after an update
    // the time keeper must not update while updateHold is high
    logic [HOLD_W-1:0] hold_ff;
    logic [HOLD_W-1:0] nxt_hold;

    always_comb begin
        nxt_hold = hold_ff;
        if (evtSet.update) begin
            nxt_hold = HOLD_W'(HOLD_CYCLES);
        end else if (hold_ff != '0) begin
            nxt_hold = hold_ff - HOLD_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (domRst) begin
            hold_ff <= '0;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    assign updateHold = hold_ff != '0;

    // ============================================================
    // read mux, latched with the address phase
    logic [31:0] rdVal;
    logic [31:0] hrdata_ff;

    always_comb begin
        rdVal = RDATA_RST;
        case (aIdx)
            IDX_EVT_ENABLE: rdVal[PERIODIC_BIT:UPDATE_BIT] = evtEn_ff;
            IDX_EVT_STATUS: begin
                rdVal[SUMMARY_BIT]            = summary;
                rdVal[PERIODIC_BIT:UPDATE_BIT] = evtFlagVec;
            end
            IDX_DAY_MATCH:  rdVal[DAY_W-1:0] = dayMatch_ff;
            IDX_CLK_CTRL: begin
                rdVal[ALM_EN_BIT]   = ctrl_ff.alarmEn;
                rdVal[WAKE_BIT]     = ctrl_ff.wakeOutGate;
                rdVal[SOFTRST_BIT]  = softRst_ff;
                rdVal[BLOCK_EN_BIT] = ctrl_ff.blockEn;
            end
            IDX_IRQ_STATUS: rdVal[PERIODIC_BIT:UPDATE_BIT] = irqFlags;
            IDX_IRQ_MASK:   rdVal[PERIODIC_BIT:UPDATE_BIT] = irqMask_ff;
            default:        rdVal = RDATA_RST;
        endcase
        if (!idxAligned) begin
            rdVal = RDATA_RST;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            hrdata_ff <= RDATA_RST;
        end else if (addrTaken && !hwrite) begin
            hrdata_ff <= rdVal;
        end
    end

    assign hrdata = hrdata_ff;

    // evtFlags kept as the typed view for readers of the waveform
    logic unusedTyped;
    assign unusedTyped = evtFlags.periodic ^ (|hsize);

endmodule

// >>> sim/rtcesc_checker.sv
// port assertions for the clock event status and control block
`timescale 1ns/1ps
module rtcesc_checker
    import rtcesc_pkg::*;
#(
    parameter int HOLD_CYCLES = int'(STABLE_CYC)
) (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        periodicTick,
    input wire logic        timeMatch,
    input wire logic        updateDone,
    input wire logic        updateHold,
    input wire logic        alarmWake,
    input wire logic        irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    // ============================================================
    // helpers
    logic        acc;
    logic [3:0]  accHist_ff;
    logic [31:0] holdCnt_ff;
    assign acc = hsel && hready && htrans[1];
    // irq may only move shortly after a bus access or an event
    always_ff @(posedge clock) begin
        accHist_ff <= rstn ? {accHist_ff[2:0], acc} : 4'h0;
    end
    always_ff @(posedge clock) begin
        if (!rstn || !updateHold || updateDone) begin
            holdCnt_ff <= 32'h0;
        end else begin
            holdCnt_ff <= holdCnt_ff + 32'h1;
        end
    end

    // ============================================================
    // properties
    sequence s_stat_rd;
        acc && !hwrite && haddr == {22'h0, IDX_EVT_STATUS, 2'b00} ##1 1'b1;
    endsequence
    property p_status_fmt;
        s_stat_rd |-> hrdata[3:0] == 4'h0 && (!hrdata[7] || hrdata[6:4] != 3'h0);
    endproperty
    property p_irq_rise;
        $rose(irq) |-> $past(periodicTick || timeMatch || updateDone, 2) || (|accHist_ff);
    endproperty
    property p_irq_fall;
        $fell(irq) |-> |accHist_ff;
    endproperty
    property p_wake_cause;
        alarmWake |-> $past(timeMatch);
    endproperty
    property p_hold_cause;
        $rose(updateHold) |-> $past(updateDone);
    endproperty
    property p_hold_len;
        holdCnt_ff <= HOLD_CYCLES;
    endproperty
    property p_okay;
        hreadyout && !hresp;
    endproperty
    property p_word;
        hrdata[31:8] == 24'h0;
    endproperty

    a_status_fmt: assert property (p_status_fmt) else $error("status read format wrong");
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
    a_wake_cause: assert property (p_wake_cause) else $error("wake without alarm");
    a_hold_cause: assert property (p_hold_cause) else $error("hold without update");
    a_hold_len: assert property (p_hold_len) else $error("hold too long");
    a_okay: assert property (p_okay) else $error("bus not ready or error");
    a_word: assert property (p_word) else $error("upper read bits set");
endmodule

bind rtcesc_core rtcesc_checker #(.HOLD_CYCLES(HOLD_CYCLES)) rtcesc_checker_i (
    .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .periodicTick(periodicTick), .timeMatch(timeMatch),
    .updateDone(updateDone), .updateHold(updateHold), .alarmWake(alarmWake), .irq(irq)
);

// >>> sim/rtcesc_wake_sink.sv
// wake circuitry stand-in: counts wake pulses
`timescale 1ns/1ps
module rtcesc_wake_sink (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       alarmWake,
    output logic      [7:0] wakeCount
);
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wakeCount <= 8'h00;
        end else if (alarmWake) begin
            wakeCount <= wakeCount + 8'h01;
        end
    end
endmodule

// >>> sim/tb.sv
// self-checking bench for the clock event status and control block
`timescale 1ns/1ps
module tb
    import rtcesc_pkg::*;
;
    localparam int H = 20;
    logic        clock;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0]  ev = 3'h0;
    logic [7:0]  calMonth = 8'h00;
    logic        hreadyout, hresp, updateHold, alarmWake, irq;
    logic [31:0] hrdata;
    logic [7:0]  wakeCount;
    int          err_count = 0;
    int          num_checks = 0;

    rtcesc_core #(.HOLD_CYCLES(H)) rtcesc_core_i (
        .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .periodicTick(ev[2]),
        .timeMatch(ev[1]), .updateDone(ev[0]), .calMonth(calMonth),
        .updateHold(updateHold), .alarmWake(alarmWake), .irq(irq)
    );
    rtcesc_wake_sink rtcesc_wake_sink_i (
        .clock(clock), .rstn(rstn), .alarmWake(alarmWake), .wakeCount(wakeCount)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ============================================================
    // tasks
    task automatic close_out;
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wt;
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            err_count++;
            close_out();
        end
    endtask
    // an event pulse launched just before a read ends at its address edge
    task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, i, 2'b00};
        wt();
        ev <= 3'h0;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wt();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        acc(1'b1, i, d, r);
    endtask
    task automatic rc(input logic [7:0] i, input logic [31:0] e, input string n);
        logic [31:0] r;
        acc(1'b0, i, 32'h0, r);
        chk(n, e, r);
    endtask
    task automatic pulse(input logic [2:0] v);
        ev <= v;
        @(posedge clock);
        ev <= 3'h0;
        @(posedge clock);
    endtask

    // ============================================================
    // sequence
    initial begin
        int n;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        rc(IDX_EVT_ENABLE, 32'h0, "enable");
        rc(IDX_DAY_MATCH, 32'h0, "day");
        rc(IDX_CLK_CTRL, 32'h0, "ctrl");
        rc(8'h3f, 32'h0, "unmapped");
        pulse(3'h7);
        rc(IDX_EVT_STATUS, 32'h0, "status off");
        wr(IDX_CLK_CTRL, 32'h1);
        pulse(3'h5);
        rc(IDX_EVT_STATUS, 32'h50, "status");
        rc(IDX_EVT_STATUS, 32'h0, "cleared");
        pulse(3'h2);
        rc(IDX_EVT_STATUS, 32'h0, "alarm off");
        wr(IDX_CLK_CTRL, 32'h9);
        pulse(3'h2);
        rc(IDX_EVT_STATUS, 32'h20, "alarm");
        chk("gated wake", 32'h0, {24'h0, wakeCount});
        wr(IDX_EVT_ENABLE, 32'h70);
        for (int i = 0; i < 3; i++) begin
            pulse(3'h1 << i);
            rc(IDX_EVT_STATUS, 32'h80 | (32'h10 << i), "summary");
        end
        wr(IDX_DAY_MATCH, 32'h5);
        calMonth <= 8'h03;
        pulse(3'h2);
        rc(IDX_EVT_STATUS, 32'h0, "day miss");
        calMonth <= 8'h05;
        pulse(3'h2);
        rc(IDX_EVT_STATUS, 32'ha0, "day hit");
        wr(IDX_DAY_MATCH, 32'h0);
        calMonth <= 8'h03;
        pulse(3'h2);
        rc(IDX_EVT_STATUS, 32'ha0, "day any");
        wr(IDX_CLK_CTRL, 32'hd);
        wr(IDX_IRQ_MASK, 32'h20);
        pulse(3'h2);
        @(posedge clock);
        @(negedge clock);
        chk("wake", 32'h1, {24'h0, wakeCount});
        chk("irq up", 32'h1, {31'h0, irq});
        rc(IDX_IRQ_STATUS, 32'h70, "irq status");
        rc(IDX_EVT_STATUS, 32'ha0, "status");
        @(negedge clock);
        chk("irq down", 32'h0, {31'h0, irq});
        wr(IDX_IRQ_MASK, 32'h0);
        pulse(3'h2);
        repeat (2) @(negedge clock);
        chk("irq masked", 32'h0, {31'h0, irq});
        rc(IDX_IRQ_STATUS, 32'h20, "irq sticky");
        wr(IDX_EVT_ENABLE, 32'h0);
        ev <= 3'h4;
        rc(IDX_EVT_STATUS, 32'h20, "same edge");
        rc(IDX_EVT_STATUS, 32'h40, "kept");
        n = 0;
        ev <= 3'h1;
        @(posedge clock);
        ev <= 3'h0;
        for (int k = 0; k < 2 * H; k++) begin
            @(negedge clock);
            if (updateHold === 1'b1) n++;
        end
        chk("hold", H, n);
        wr(IDX_DAY_MATCH, 32'h7);
        wr(IDX_EVT_ENABLE, 32'h70);
        pulse(3'h4);
        wr(IDX_CLK_CTRL, 32'hb);
        repeat (2) @(posedge clock);
        rc(IDX_CLK_CTRL, 32'h9, "ctrl kept");
        rc(IDX_DAY_MATCH, 32'h0, "day reset");
        rc(IDX_EVT_ENABLE, 32'h0, "enable reset");
        rc(IDX_EVT_STATUS, 32'h0, "status reset");
        close_out();
    end
endmodule
